// >>> core/ptc_core.sv
// Strobed register access was chosen for this implementation.
`include "ptc_regs.svh"
// How it works
// - Reserved upper bits of both registers ignore writes and read zero.
// - Test bit 4 picks 10Base-T patterns when one, 100Base-TX when zero.
// - In 10Base-T mode the low four bits pick the driven pattern.
// - 100Base-TX mode repeats a one then {bit5,bits3:0} zeros, 1 to 31.
// - An all-zero 100Base-TX field stops the test sequence.
// - Transmit clock phase stays fixed unless software asks for a shift.
// - Phase is counted in 4 ns steps, valid from 0 to 10 steps.
// - Phase values above ten are stored and applied modulo ten.
// - Enable bit one starts a shift; zero leaves the phase alone.
// - Phase field reads the current offset; shift equals the difference.
module ptc_core
  import ptc_pkg::*;
#(
  parameter int ADDR_W = `PTC_ADDR_W,
  parameter int DATA_W = `PTC_DATA_W,
  parameter int SETTLE_CYC = `PTC_SETTLE_CYC
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic test10_active,
  output ptc_pat10_type test10_pattern,
  output logic test100_active,
  output logic test100_bit,
  output ptc_phase_type tx_clk_phase_sel
);
  // ==========================================
  // Reset release
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================
  // Helpers
  function automatic ptc_phase_type ptc_mod_ten(input logic [3:0] v);
    ptc_mod_ten = (v > `PTC_PHASE_MAX) ? v - `PTC_PHASE_MAX : v;
  endfunction : ptc_mod_ten

  function automatic ptc_pat10_type ptc_pat10(input logic [3:0] c);
    case (c)
      4'h0: ptc_pat10 = PAT_NLP;
      4'h1: ptc_pat10 = PAT_PULSE1;
      4'h2: ptc_pat10 = PAT_PULSE0;
      4'h3: ptc_pat10 = PAT_REP1;
      4'h4: ptc_pat10 = PAT_REP0;
      4'h5: ptc_pat10 = PAT_PREAMBLE;
      4'h6: ptc_pat10 = PAT_ONE_IDLE;
      4'h7: ptc_pat10 = PAT_ZERO_IDLE;
      4'h8: ptc_pat10 = PAT_1001;
      4'h9: ptc_pat10 = PAT_RANDOM;
      4'hA: ptc_pat10 = PAT_IDLE_00;
      4'hB: ptc_pat10 = PAT_IDLE_10;
      4'hD: ptc_pat10 = PAT_IDLE_11;
      default: ptc_pat10 = PAT_NONE;
    endcase
  endfunction : ptc_pat10

  // ==========================================
  // Address decode
  wire hit_test = (reg_addr == ADDR_W'(`PTC_TEST_OFS));
  wire hit_phase = (reg_addr == ADDR_W'(`PTC_PHASE_OFS));
  wire wr_test = reg_wr && hit_test;
  wire wr_phase = reg_wr && hit_phase;
  wire phase_start = wr_phase && reg_wdata[`PTC_PHASE_EN_BIT];
  wire [3:0] phase_wval = reg_wdata[3:0];

  // ==========================================
  // Registers
  // Only the low six test bits are kept; the rest is never stored
  logic [`PTC_TEST_W-1:0] test_q;
  logic phase_en_q;
  ptc_phase_if pif ();

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      test_q <= `PTC_TEST_RST;
    else if (wr_test)
      test_q <= reg_wdata[`PTC_TEST_W-1:0];
  end

  // Set wins: a new request in the clearing cycle keeps the bit up
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      phase_en_q <= 1'b0;
    else if (phase_start)
      phase_en_q <= 1'b1;
    else if (phase_en_q && !pif.busy)
      phase_en_q <= 1'b0;
  end

  assign pif.start = phase_start;
  assign pif.target = ptc_mod_ten(phase_wval);

  ptc_phase_step #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_phase (
    .clk(clk),
    .rst_n(rst_n_q),
    .pif(pif)
  );

  assign tx_clk_phase_sel = pif.current;

  // ==========================================
  // Read port
  wire [DATA_W-1:0] test_rd = {{(DATA_W-`PTC_TEST_W){1'b0}}, test_q};
  wire [DATA_W-1:0] phase_rd =
    {{(DATA_W-5){1'b0}}, phase_en_q, pif.current};
  wire [DATA_W-1:0] rd_mux =
    hit_test ? test_rd : (hit_phase ? phase_rd : '0);
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= '0;
    else
      rdata_q <= reg_rd ? rd_mux : '0;
  end

  assign reg_rdata = rdata_q;

  // ==========================================
  // Test family selection
  wire family_10 = test_q[`PTC_TEST_FAMILY_BIT];
  wire [4:0] zero_run = {test_q[`PTC_TEST_MSB_BIT], test_q[3:0]};
  wire run_on = !family_10 && (zero_run != 5'h00);
  ptc_pat10_type pat_dec;
  assign pat_dec = ptc_pat10(test_q[3:0]);
  wire pat_ok = (ptc_pat10(test_q[3:0]) != PAT_NONE);

  logic t10_act_q;
  ptc_pat10_type t10_pat_q;

  // Undefined codes drive nothing rather than a guessed pattern
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      t10_act_q <= 1'b0;
      t10_pat_q <= PAT_NONE;
    end
    else
    begin
      t10_act_q <= family_10 && pat_ok;
      t10_pat_q <= family_10 ? pat_dec : PAT_NONE;
    end
  end

  assign test10_active = t10_act_q;
  assign test10_pattern = t10_pat_q;

  // ==========================================
  // 100Base-TX sequence
  // A rewrite restarts at the leading one; no half run is emitted
  ptc_tx_state_type st_q;
  ptc_tx_state_type st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic bit_q;
  logic act_q;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      TX_IDLE:
      begin
        if (run_on)
          st_d = TX_ONE;
      end
      TX_ONE:
      begin
        cnt_d = 5'h01;
        st_d = TX_ZERO;
      end
      TX_ZERO:
      begin
        if (cnt_q == zero_run)
          st_d = TX_ONE;
        else
          cnt_d = cnt_q + 5'h01;
      end
      default:
        st_d = TX_IDLE;
    endcase
    if (!run_on || wr_test)
    begin
      st_d = TX_IDLE;
      cnt_d = 5'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q <= TX_IDLE;
      cnt_q <= 5'h00;
      bit_q <= 1'b0;
      act_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= (st_d == TX_ONE);
      act_q <= (st_d != TX_IDLE);
    end
  end

  assign test100_active = act_q;
  assign test100_bit = bit_q;

  // ==========================================
  // Checks
  logic [4:0] zeros_seen_q;
  ptc_phase_type exp_phase_q;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      zeros_seen_q <= 5'h00;
      exp_phase_q <= 4'h0;
    end
    else
    begin
      if (!act_q || bit_q)
        zeros_seen_q <= 5'h00;
      else
        zeros_seen_q <= zeros_seen_q + 5'h01;
      if (phase_start)
        exp_phase_q <= (phase_wval > 4'hA) ? phase_wval % 4'hA : phase_wval;
    end
  end

  a_rsvd_test_zero: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (reg_rd && hit_test) |=> (reg_rdata[15:6] == 10'h000)
  ) else $error("test register upper bits not zero");

  a_rsvd_phase_zero: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (reg_rd && hit_phase) |=> (reg_rdata[15:5] == 11'h000)
  ) else $error("phase register upper bits not zero");

  a_family_ten: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (wr_test && reg_wdata[4]) |=> ##1 (!test100_active && !test100_bit)
  ) else $error("100TX sequence running in 10BT family");

  a_pat_ten_drive: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (wr_test && reg_wdata[4] && reg_wdata[3:0] == 4'h5) |=> ##1
      (test10_active && test10_pattern == PAT_PREAMBLE)
  ) else $error("10BT pattern not driven");

  a_zero_run_len: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (act_q && bit_q && zeros_seen_q != 5'h00 && $stable(test_q)) |->
      (zeros_seen_q == zero_run)
  ) else $error("wrong number of zeros after a one");

  // A later test write restarts the run, so only quiet cycles count
  a_run_start: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (wr_test && !reg_wdata[4] && reg_wdata[3:0] != 4'h0)
      ##1 (!wr_test)[*2] |->
      (test100_active && test100_bit) ##1 (test100_active && !test100_bit)
  ) else $error("100TX sequence did not start with one then zero");

  a_field_clear: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (wr_test && reg_wdata[5] == 1'b0 && reg_wdata[3:0] == 4'h0)
      ##1 (!wr_test)[*2] |->
      (!test100_active && !test100_bit)[*3]
  ) else $error("zero field did not stop the sequence");

  a_phase_hold: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (!phase_en_q && !phase_start) |=> $stable(tx_clk_phase_sel)
  ) else $error("phase moved without a request");

  a_phase_mod_ten: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    $fell(phase_en_q) |-> (tx_clk_phase_sel == exp_phase_q)
  ) else $error("applied phase differs from written value");

  a_enable_clears: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    phase_start |=> phase_en_q ##[0:60] !phase_en_q
  ) else $error("enable bit did not self clear");

  a_phase_readback: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (reg_rd && hit_phase) |=>
      (reg_rdata[3:0] == $past(tx_clk_phase_sel)
       && reg_rdata[4] == $past(phase_en_q))
  ) else $error("phase read back wrong");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (reg_rd && !hit_test && !hit_phase) |=> (reg_rdata == '0)
  ) else $error("unmapped read not zero");

  a_rdata_idle_zero: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    !reg_rd |=> (reg_rdata == '0)
  ) else $error("read data outside answer cycle");

  a_value_write_ignored: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (wr_phase && !reg_wdata[4] && !phase_en_q) |=>
      (!phase_en_q && $stable(tx_clk_phase_sel))
  ) else $error("phase moved on a write without enable");

  a_undef_code_idle: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (wr_test && reg_wdata[4] && (reg_wdata[3:0] == 4'hC
      || reg_wdata[3:0] >= 4'hE)) |=> ##1
      (!test10_active && test10_pattern == PAT_NONE)
  ) else $error("undefined 10BT code drove a pattern");
endmodule : ptc_core

// >>> core/ptc_regs.svh
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH
// ==========================================
// Register map
`define PTC_ADDR_W 16
`define PTC_DATA_W 16
`define PTC_TEST_OFS 16'h0027
`define PTC_PHASE_OFS 16'h0042
`define PTC_TEST_RST 6'h00
`define PTC_PHASE_RST 4'h0
// ==========================================
// Field positions
`define PTC_TEST_FAMILY_BIT 4
`define PTC_TEST_MSB_BIT 5
`define PTC_TEST_W 6
`define PTC_PHASE_EN_BIT 4
`define PTC_PHASE_W 4
// ==========================================
// Timing
`define PTC_STEP_NS 4
`define PTC_PHASE_MAX 4'hA
`define PTC_CLK_MHZ 25
`define PTC_SETTLE_NS 80
`define PTC_SETTLE_CYC ((`PTC_SETTLE_NS * `PTC_CLK_MHZ + 999) / 1000)
`endif

// >>> core/ptc_pkg.sv
package ptc_pkg;
  typedef logic [3:0] ptc_phase_type;
  typedef enum logic [3:0] {
    PAT_NLP, PAT_PULSE1, PAT_PULSE0, PAT_REP1, PAT_REP0,
    PAT_PREAMBLE, PAT_ONE_IDLE, PAT_ZERO_IDLE, PAT_1001,
    PAT_RANDOM, PAT_IDLE_00, PAT_IDLE_10, PAT_IDLE_11, PAT_NONE
  } ptc_pat10_type;
  typedef enum logic [1:0] {TX_IDLE, TX_ONE, TX_ZERO} ptc_tx_state_type;
endpackage : ptc_pkg

// >>> core/ptc_phase_if.sv
interface ptc_phase_if;
  import ptc_pkg::*;
  logic start;
  ptc_phase_type target;
  ptc_phase_type current;
  logic busy;
  modport ctl (output start, output target, input current, input busy);
  modport ph (input start, input target, output current, output busy);
endinterface : ptc_phase_if

// >>> core/ptc_phase_step.sv
`include "ptc_regs.svh"
module ptc_phase_step
  import ptc_pkg::*;
#(
  parameter int SETTLE_CYC = `PTC_SETTLE_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  ptc_phase_if.ph pif
);
  localparam int GW = $clog2(SETTLE_CYC + 1);
  localparam logic [GW-1:0] GAP_LOAD = GW'(SETTLE_CYC);

  // ==========================================
  // Tap stepping
  // One tap per settle window, so the delay line never jumps far
  ptc_phase_type cur_q;
  ptc_phase_type tgt_q;
  logic [GW-1:0] gap_q;
  wire gap_done = (gap_q == '0);
  wire need_up = (cur_q < tgt_q);
  wire need_dn = (cur_q > tgt_q);
  wire do_step = gap_done && (need_up || need_dn);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_q <= `PTC_PHASE_RST;
      tgt_q <= `PTC_PHASE_RST;
      gap_q <= '0;
    end
    else
    begin
      if (pif.start)
        tgt_q <= pif.target;
      if (do_step)
      begin
        cur_q <= need_up ? cur_q + 4'h1 : cur_q - 4'h1;
        gap_q <= GAP_LOAD;
      end
      else if (!gap_done)
        gap_q <= gap_q - GW'(1);
    end
  end

  assign pif.current = cur_q;
  assign pif.busy = need_up || need_dn || !gap_done;

  a_tap_single_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cur_q != $past(cur_q)) |->
      ((cur_q - $past(cur_q) == 4'h1) || ($past(cur_q) - cur_q == 4'h1))
  ) else $error("tap moved more than one step");

  a_tap_in_range: assert property (
    @(posedge clk) disable iff (!rst_n)
    cur_q <= `PTC_PHASE_MAX
  ) else $error("tap beyond forty ns");
endmodule : ptc_phase_step

// >>> verif/ptc_mgmt_model.sv
`include "ptc_regs.svh"
module ptc_mgmt_model
(
  input wire logic clk,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BASIC_MODE_CTRL_ADDR = 16'h0000;
  localparam logic [15:0] SPEED_FORCED = 16'h2100;
  logic [4:0] field_q;
  logic forced_q;
  initial
  begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    field_q = 5'h00;
    forced_q = 1'b0;
  end
  // ====================
  // One bus cycle
  task automatic cycle(input logic w, input logic [15:0] a,
    input logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Released bus shows junk, so stale values cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : cycle
  // ====================
  // Register access
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [4:0] f;
    f = {d[5], d[3:0]};
    if (a == `PTC_TEST_OFS && f != 5'h00 && !forced_q)
    begin
      cycle(1'b1, BASIC_MODE_CTRL_ADDR, SPEED_FORCED);
      forced_q = 1'b1;
    end
    if (a == `PTC_TEST_OFS && f != 5'h00 && field_q != 5'h00 && f != field_q)
      cycle(1'b1, a, 16'h0000);
    if (a == `PTC_TEST_OFS)
      field_q = f;
    cycle(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    cycle(1'b0, a, 16'h0000);
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : ptc_mgmt_model

// >>> verif/test_phy_test_pattern_and_txclk_phase.sv
`include "ptc_regs.svh"
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end
module test_phy_test_pattern_and_txclk_phase
  import ptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [15:0] wd;
    logic [15:0] rd;
    logic a10;
    ptc_pat10_type pat;
    logic a100;
  } ptc_row_type;
  logic clk;
  logic rst_b;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic test10_active;
  ptc_pat10_type test10_pattern;
  logic test100_active;
  logic test100_bit;
  ptc_phase_type tx_clk_phase_sel;
  ptc_phase_type last_sel;
  wire step_ok = (tx_clk_phase_sel <= 4'ha)
    && ((tx_clk_phase_sel - last_sel) == 4'h1
    || (last_sel - tx_clk_phase_sel) == 4'h1);
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  ptc_row_type rows[$];
  ptc_pat10_type pats[16] = '{PAT_NLP, PAT_PULSE1, PAT_PULSE0, PAT_REP1,
    PAT_REP0, PAT_PREAMBLE, PAT_ONE_IDLE, PAT_ZERO_IDLE, PAT_1001,
    PAT_RANDOM, PAT_IDLE_00, PAT_IDLE_10, PAT_NONE, PAT_IDLE_11, PAT_NONE,
    PAT_NONE};
  ptc_core #(.SETTLE_CYC(1)) uut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .test10_active(test10_active),
    .test10_pattern(test10_pattern), .test100_active(test100_active),
    .test100_bit(test100_bit), .tx_clk_phase_sel(tx_clk_phase_sel));
  ptc_mgmt_model mgmt (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ====================
  // Tap moves one step at a time, never past ten
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
    if (rst_b && tx_clk_phase_sel !== last_sel)
      `CHK(step_ok, 1'b1)
    last_sel <= tx_clk_phase_sel;
  end
  // ====================
  // Tasks
  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic seq_check(input int n);
    mgmt.wr(`PTC_TEST_OFS, {10'h000, n[4], 1'b0, n[3:0]});
    // Leading one stands from the second edge after the write
    repeat (1) @(posedge clk);
    for (int k = 0; k < 2 * (n + 1); k++)
    begin
      #1;
      `CHK(test100_bit, logic'(k % (n + 1) == 0))
      @(posedge clk);
    end
  endtask : seq_check
  task automatic phase_to(input logic [15:0] wd, input ptc_phase_type e);
    logic [15:0] d;
    mgmt.wr(`PTC_PHASE_OFS, wd);
    d = 16'h0010;
    // Self-clearing enable is polled, bounded
    for (int n = 0; n < 60 && d[4]; n++)
      mgmt.rd(`PTC_PHASE_OFS, d);
    `CHK(d, {12'h000, e})
    `CHK(tx_clk_phase_sel, e)
  endtask : phase_to
  // ====================
  // Main sequence
  initial
  begin
    logic [15:0] d;
    rst_b = 1'b0;
    last_sel = 4'h0;
    for (int i = 0; i < 16; i++)
      rows.push_back('{16'hfff0 | 16'(i), 16'h0030 | 16'(i),
        pats[i] != PAT_NONE, pats[i], 1'b0});
    rows.push_back('{16'hffc1, 16'h0001, 1'b0, PAT_NONE, 1'b1});
    rows.push_back('{16'hffef, 16'h002f, 1'b0, PAT_NONE, 1'b1});
    rows.push_back('{16'h0000, 16'h0000, 1'b0, PAT_NONE, 1'b0});
    do_reset();
    `CHK(test10_pattern, PAT_NONE)
    `CHK(tx_clk_phase_sel, 4'h0)
    mgmt.rd(`PTC_TEST_OFS, d);
    `CHK(d, 16'h0000)
    mgmt.rd(16'h0100, d);
    `CHK(d, 16'h0000)
    $display("test done: reset");
    foreach (rows[i])
    begin
      mgmt.wr(`PTC_TEST_OFS, rows[i].wd);
      repeat (2) @(posedge clk);
      #1;
      `CHK(test10_active, rows[i].a10)
      `CHK(test10_pattern, rows[i].pat)
      `CHK(test100_active, rows[i].a100)
      mgmt.rd(`PTC_TEST_OFS, d);
      `CHK(d, rows[i].rd)
    end
    $display("test done: rows");
    seq_check(1);
    seq_check(3);
    seq_check(31);
    $display("test done: serial");
    phase_to(16'hfff2, 4'h2);
    phase_to(16'h000d, 4'h2);
    phase_to(16'h001f, 4'h5);
    phase_to(16'h001a, 4'ha);
    phase_to(16'h001b, 4'h1);
    $display("test done: phase");
    mgmt.wr(`PTC_TEST_OFS, 16'h0015);
    phase_to(16'h0014, 4'h4);
    do_reset();
    `CHK(test10_active, 1'b0)
    `CHK(tx_clk_phase_sel, 4'h0)
    mgmt.rd(`PTC_PHASE_OFS, d);
    `CHK(d, 16'h0000)
    $display("test done: second reset");
    results();
  end
endmodule : test_phy_test_pattern_and_txclk_phase
